// file: usch_hopper.sv
// Contract
// - Slotted hopping runs only when transmission type equals 1
// - Transmit start pulses exactly at the start of the chosen slot; the code pulses one cycle after the slot's first cycle
// - Frame split into numbered slots; only enabled slots carry data
// - Sender address is the 32-bit header address, one hop input
// - Time word: 12-bit week count high, 20-bit week seconds low
// - Week values from elapsed seconds by divide and modulo 604800
// - Path space = slots times channels^(repeats+1); width = ceil log2
// - Scale = ceil(path/(2^width-1)*64)/64, six fraction bits
// - Candidate = floor(raw seed times scale)
// - Retry while candidate too big, four tries, then halve it
// - Slot index = seed mod slots; quotient goes on
// - Quotient divided by channels per copy; remainders are channels
// - Address shifter seeded with sender address, its polynomial
// - Time shifter seeded with time word, its polynomial
// - Raw seed is bitwise XOR of both shifter outputs
// - Band over 200 kHz splits into 200 kHz channels
`include "usch_defines.svh"
`default_nettype none
module usch_hopper
   import usch_pkg::*;
#(
   parameter int MAX_COPIES = 8
) (
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst,
   // AXI4-Lite write
   input  wire  logic [7:0]  awaddr,
   input  wire  logic        awvalid,
   output logic              awready,
   input  wire  logic [31:0] wdata,
   input  wire  logic [3:0]  wstrb,
   input  wire  logic        wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire  logic        bready,
   // AXI4-Lite read
   input  wire  logic [7:0]  araddr,
   input  wire  logic        arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire  logic        rready,
   // Scheduler side
   output logic              hopDone,
   output logic              txStart,
   output logic [31:0]       slotIndex
);
   localparam int W = 64;
   logic [31:0] ctrl_q, addr_q, secs_q, cfg_q, slotTime_q, slotEn_q;
   logic [31:0] bandKhz_q;
   logic        start_q;
   usch_state_type state_q;
   logic [W-1:0] num_q, den_q, quo_q, rem_q, path_q;
   logic [6:0]   bit_q;
   logic [5:0]   width_q, step_q;
   logic [31:0]  aSh_q, tSh_q, raw_q;
   logic [W-1:0] alpha_q, cand_q;
   logic [2:0]   tries_q;
   logic [3:0]   copy_q;
   logic [31:0]  slot_q;
   logic [31:0]  chan_q [MAX_COPIES];
   logic         done_q;
   logic [31:0]  slotCnt_q, curSlot_q;
   logic         armed_q;

   wire [15:0] nSlots = cfg_q[`USCH_CFG_SLOTS_LSB +: 16];
   wire [3:0]  nRep = cfg_q[`USCH_CFG_REP_LSB +: 4];
   wire        syncMode = ctrl_q[`USCH_TYPE_LSB +: `USCH_TYPE_W]
                          == `USCH_TYPE_SYNC;
   // Channel count from band width, one if band is narrow
   wire [31:0] nChan = (bandKhz_q > `USCH_CHAN_KHZ) ?
                       bandKhz_q / `USCH_CHAN_KHZ : 32'h1;

   // Write path: take address and data in either order
   logic        awHave_q, wHave_q;
   logic [7:0]  wa_q;
   logic [31:0] wd_q;
   assign awready = !awHave_q && !bvalid;
   assign wready  = !wHave_q && !bvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         awHave_q <= 1'b0; wHave_q <= 1'b0; bvalid <= 1'b0;
         wa_q <= 8'h00; wd_q <= 32'h0;
      end else begin
         if (awvalid && awready) begin
            awHave_q <= 1'b1; wa_q <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_q <= 1'b1; wd_q <= wdata;
         end
         if (awHave_q && wHave_q) begin
            awHave_q <= 1'b0; wHave_q <= 1'b0; bvalid <= 1'b1;
         end
         if (bvalid && bready) bvalid <= 1'b0;
      end
   end
   assign bresp = 2'b00;
   wire doWr = awHave_q && wHave_q;

   // Register writes; strobes ignored, full words assumed
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= 32'h0; addr_q <= 32'h0; secs_q <= 32'h0;
         cfg_q <= `USCH_CFG_RST; slotTime_q <= `USCH_SLOTTIME_RST;
         slotEn_q <= 32'hFFFFFFFF; bandKhz_q <= 32'h0; start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (doWr) begin
            case (wa_q)
               `USCH_CTRL_OFS: begin
                  ctrl_q  <= wd_q;
                  start_q <= wd_q[`USCH_CTRL_START];
               end
               `USCH_ADDR_OFS:     addr_q <= wd_q;
               `USCH_SECS_OFS:     secs_q <= wd_q;
               `USCH_CFG_OFS:      cfg_q <= wd_q;
               `USCH_SLOTCFG_OFS:  bandKhz_q <= wd_q;
               `USCH_SLOTTIME_OFS: slotTime_q <= wd_q;
               `USCH_SLOTEN_OFS:   slotEn_q <= wd_q;
               default: ;
            endcase
         end
      end
   end

   // Read path, one cycle latency, unmapped reads zero with slave error
   assign arready = !rvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'b00;
      end else begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= 2'b00;
            case (araddr)
               `USCH_CTRL_OFS:  rdata <= ctrl_q;
               `USCH_ADDR_OFS:  rdata <= addr_q;
               `USCH_SECS_OFS:  rdata <= secs_q;
               `USCH_CFG_OFS:   rdata <= cfg_q;
               `USCH_STAT_OFS:  rdata <= {27'h0, tries_q, armed_q, done_q};
               `USCH_SLOT_OFS:  rdata <= slot_q;
               `USCH_CHAN_OFS:  rdata <= chan_q[ctrl_q[11:8] % MAX_COPIES];
               `USCH_SEED_OFS:  rdata <= cand_q[31:0];
               `USCH_SLOTCFG_OFS:  rdata <= bandKhz_q;
               `USCH_SLOTTIME_OFS: rdata <= slotTime_q;
               `USCH_SLOTEN_OFS:   rdata <= slotEn_q;
               default: begin
                  rdata <= 32'h0;
                  rresp <= 2'b10;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Shared restoring divider: one quotient bit per cycle
   wire [W:0] trial = {rem_q, num_q[W-1]} - {1'b0, den_q};
   wire       divBusy = (bit_q != 7'd0);
   wire [W-1:0] seedMask = (W'(1) << width_q) - W'(1);
   wire [W-1:0] rawSeed = W'(raw_q) & seedMask;
   wire [2*W-1:0] prod = rawSeed * alpha_q;

   // Main sequence; divider shared by the week, scale, slot and channel divisions
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= IDLE; num_q <= '0; den_q <= '0; quo_q <= '0;
         rem_q <= '0; bit_q <= 7'd0; path_q <= '0; width_q <= 6'd0;
         step_q <= 6'd0; aSh_q <= 32'h0; tSh_q <= 32'h0; raw_q <= 32'h0;
         alpha_q <= '0; cand_q <= '0; tries_q <= 3'h0; copy_q <= 4'h0;
         slot_q <= 32'h0;
         done_q <= 1'b0;
         for (int i = 0; i < MAX_COPIES; i++) chan_q[i] <= 32'h0;
      end else if (divBusy) begin
         num_q <= {num_q[W-2:0], 1'b0};
         if (!trial[W]) begin
            rem_q <= trial[W-1:0];
            quo_q <= {quo_q[W-2:0], 1'b1};
         end else begin
            rem_q <= {rem_q[W-2:0], num_q[W-1]};
            quo_q <= {quo_q[W-2:0], 1'b0};
         end
         bit_q <= bit_q - 7'd1;
      end else begin
         case (state_q)
            IDLE: begin
               // Any start drops the old result, sync mode or not
               if (start_q) done_q <= 1'b0;
               if (start_q && syncMode) begin
                  num_q <= W'(secs_q);
                  den_q <= W'(`USCH_WEEK_SECONDS);
                  rem_q <= '0;
                  bit_q <= 7'(W);
                  state_q <= WEEKDIV;
               end
            end
            WEEKDIV: begin
               aSh_q <= addr_q;
               tSh_q <= {quo_q[11:0], rem_q[19:0]};
               path_q <= W'(nSlots);
               copy_q <= 4'h0;
               state_q <= SIZE;
            end
            SIZE: if (copy_q <= nRep) begin
               path_q <= W'(path_q * W'(nChan));
               copy_q <= copy_q + 4'h1;
            end else begin
               width_q <= 6'd0;
               for (int b = 0; b < W; b++)
                  if (path_q > (W'(1) << b)) width_q <= 6'(b + 1);
               state_q <= ALPHA;
            end
            ALPHA: begin
               num_q <= path_q << `USCH_ALPHA_FRAC;
               den_q <= (W'(1) << width_q) - W'(1);
               rem_q <= '0;
               bit_q <= 7'(W);
               tries_q <= 3'h0;
               step_q <= 6'd0;
               raw_q <= 32'h0;
               state_q <= SHIFT;
            end
            SHIFT: begin
               if (step_q == 6'd0 && tries_q == 3'h0)
                  alpha_q <= quo_q + W'(rem_q != '0);
               // Fibonacci step, output bit is msb
               aSh_q <= {aSh_q[30:0], ^(aSh_q & `USCH_ADDR_POLY)};
               tSh_q <= {tSh_q[30:0], ^(tSh_q & `USCH_TIME_POLY)};
               raw_q <= {raw_q[30:0], aSh_q[31] ^ tSh_q[31]};
               step_q <= step_q + 6'd1;
               if (step_q + 6'd1 == width_q) state_q <= SCALE;
            end
            SCALE: begin
               cand_q <= W'(prod >> `USCH_ALPHA_FRAC);
               tries_q <= tries_q + 3'h1;
               state_q <= SLOTDIV;
            end
            SLOTDIV: begin
               if (cand_q >= path_q && tries_q < `USCH_MAX_TRIES) begin
                  step_q <= 6'd0; raw_q <= 32'h0; state_q <= SHIFT;
               end else begin
                  num_q <= (cand_q >= path_q) ? cand_q >> 1 : cand_q;
                  den_q <= W'(nSlots); rem_q <= '0; bit_q <= 7'(W);
                  copy_q <= 4'h0; state_q <= CHDIV;
               end
            end
            CHDIV: begin
               if (copy_q == 4'h0) slot_q <= rem_q[31:0];
               else chan_q[(copy_q - 4'h1) % MAX_COPIES]
                       <= rem_q[31:0];
               if (copy_q <= nRep) begin
                  num_q <= quo_q; den_q <= W'(nChan);
                  rem_q <= '0; bit_q <= 7'(W);
                  copy_q <= copy_q + 4'h1;
               end else state_q <= DONE;
            end
            DONE: begin
               done_q <= 1'b1;
               state_q <= IDLE;
            end
            default: state_q <= IDLE;
         endcase
      end
   end

   // Frame timing: slot counter and start pulse at the chosen slot
   always_ff @(posedge clk) begin
      if (rst) begin
         slotCnt_q <= 32'h0;
         curSlot_q <= 32'h0;
         armed_q   <= 1'b0;
         txStart   <= 1'b0;
      end else begin
         txStart <= 1'b0;
         if (state_q == DONE) armed_q <= 1'b1;
         // A new start disarms, so a stale slot never launches
         if (start_q) armed_q <= 1'b0;
         if (slotCnt_q + 32'h1 >= slotTime_q) begin
            slotCnt_q <= 32'h0;
            curSlot_q <= (curSlot_q + 32'h1 >= 32'(nSlots)) ?
                         32'h0 : curSlot_q + 32'h1;
         end else slotCnt_q <= slotCnt_q + 32'h1;
         // Pulse decided on the slot's first cycle only, output one cycle later
         if (armed_q && !start_q && syncMode && slotCnt_q == 32'h0 &&
             curSlot_q == slot_q && slotEn_q[curSlot_q[4:0]]) begin
            txStart <= 1'b1;
            armed_q <= 1'b0;
         end
      end
   end

   assign hopDone   = done_q;
   assign slotIndex = slot_q;
endmodule : usch_hopper
`default_nettype wire

// file: usch_defines.svh
`ifndef USCH_DEFINES_SVH
`define USCH_DEFINES_SVH

// Register byte offsets
`define USCH_CTRL_OFS      8'h00
`define USCH_ADDR_OFS      8'h04
`define USCH_SECS_OFS      8'h08
`define USCH_CFG_OFS       8'h0C
`define USCH_STAT_OFS      8'h10
`define USCH_SLOT_OFS      8'h14
`define USCH_CHAN_OFS      8'h18
`define USCH_SEED_OFS      8'h1C
`define USCH_SLOTCFG_OFS   8'h20
`define USCH_SLOTTIME_OFS  8'h24
`define USCH_SLOTEN_OFS    8'h28

// Field positions in control
`define USCH_CTRL_START    0
`define USCH_TYPE_LSB      4
`define USCH_TYPE_W        4
`define USCH_TYPE_SYNC     4'h1

// Field positions in configuration
`define USCH_CFG_SLOTS_LSB 0
`define USCH_CFG_CHAN_LSB  16
`define USCH_CFG_REP_LSB   24

// Time word layout
`define USCH_WEEK_W        12
`define USCH_WSEC_W        20
`define USCH_WEEK_SECONDS  32'h00093A80

// Seed handling
`define USCH_ALPHA_FRAC    6
`define USCH_MAX_TRIES     3'h4

// Feedback taps: bit k-1 stands for term x^k, the +1 is implicit
`define USCH_ADDR_POLY     32'h80000057
`define USCH_TIME_POLY     32'hA0010805

// Band split
`define USCH_CHAN_KHZ      200

// Reset values
`define USCH_CFG_RST       32'h0004_0271
`define USCH_SLOTTIME_RST  32'h0000_03E8

`endif

// file: usch_pkg.sv
`default_nettype none
package usch_pkg;
   typedef enum logic [3:0] {
      IDLE, WEEKDIV, SIZE, ALPHA, SHIFT, SCALE, SLOTDIV, CHDIV, DONE
   } usch_state_type;
endpackage : usch_pkg
`default_nettype wire

// file: usch_hopper_asserts.sv
`default_nettype none
module usch_hopper_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Bus handshakes
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   // Scheduler side
   input wire logic        hopDone,
   input wire logic        txStart,
   input wire logic [31:0] slotIndex
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Handshake steps
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rd_taken;
      arvalid && arready;
   endsequence
   // Bus answers with the promised latency
   a_wr_answer: assert property (wr_taken |-> ##2 bvalid)
      else $error("write response not two cycles on");
   a_rd_answer: assert property (rd_taken |=> rvalid)
      else $error("read data not one cycle on");
   a_wr_okay: assert property (bvalid |-> bresp == 2'h0)
      else $error("write response not okay");
   a_wr_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answering");
   a_rd_refuse: assert property (rvalid |-> !arready)
      else $error("read taken while answering");
   a_rd_clear: assert property (rvalid && rready |=> !rvalid)
      else $error("read data kept after handshake");
   // Launch is one pulse and only on a finished hop
   a_tx_pulse: assert property (txStart |=> !txStart)
      else $error("launch longer than one cycle");
   a_tx_done: assert property (txStart |-> hopDone)
      else $error("launch without finished hop");
   a_slot_hold: assert property (hopDone && $past(hopDone) |->
      $stable(slotIndex)) else $error("slot moved after done");
endmodule : usch_hopper_chk
bind usch_hopper usch_hopper_chk chk_u (.clk(clk), .rst(rst),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready),
   .hopDone(hopDone), .txStart(txStart), .slotIndex(slotIndex));
`default_nettype wire

// file: usch_sched_model.sv
`default_nettype none
module usch_sched_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // From the hopper
   input  wire logic        txStart,
   input  wire logic [31:0] slotIndex,
   // Observed launches
   output var  logic [15:0] txCount_q,
   output var  logic [31:0] lastSlot_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // Scheduler only counts launches and keeps the last launched slot; it cannot stall the hopper
   always_ff @(posedge clk) begin
      if (rst) begin
         txCount_q  <= 16'h0;
         lastSlot_q <= 32'h0;
      end else if (txStart) begin
         txCount_q  <= txCount_q + 16'h1;
         lastSlot_q <= slotIndex;
      end
   end
endmodule : usch_sched_model
`default_nettype wire

// file: usch_hopper_tb_top.sv
`include "usch_defines.svh"
`default_nettype none
module usch_hopper_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, hopDone, txStart;
   logic [7:0]  awaddr, araddr;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] wdata, rdata, slotIndex, lastSlot, d, rng = 32'hFEBF;
   logic [15:0] txCount;
   int          errCount = 0, numChecks = 0, cyc = 0, i;

   usch_hopper #(.MAX_COPIES(8)) dut_u (.clk(clk), .rst(rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .hopDone(hopDone),
      .txStart(txStart), .slotIndex(slotIndex));
   usch_sched_model model_u (.clk(clk), .rst(rst), .txStart(txStart),
      .slotIndex(slotIndex), .txCount_q(txCount), .lastSlot_q(lastSlot));

   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, well above eleven hops
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errCount++;
         reportAndStop();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Reference seed: both shifters, up to four tries, same scaling
   function automatic logic [31:0] refSeed(input logic [31:0] a, sec, mp);
      logic [31:0] t, rw;
      logic [63:0] p2, al, c;
      int          w;
      t = {12'(sec / `USCH_WEEK_SECONDS), 20'(sec % `USCH_WEEK_SECONDS)};
      w = $clog2(mp);
      p2 = (64'h1 << w) - 64'h1;
      al = ((64'(mp) << `USCH_ALPHA_FRAC) + p2 - 64'h1) / p2;
      c = 64'h0;
      for (int n = 0; n < 4; n++) begin
         if (n == 0 || c >= 64'(mp)) begin
            rw = 32'h0;
            repeat (w) begin
               rw = {rw[30:0], a[31] ^ t[31]};
               a = {a[30:0], ^(a & `USCH_ADDR_POLY)};
               t = {t[30:0], ^(t & `USCH_TIME_POLY)};
            end
            c = (64'(rw) * al) >> `USCH_ALPHA_FRAC;
         end
      end
      return c[31:0];
   endfunction : refSeed
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rr);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : rd
   // One hop run; expectations follow from the returned seed
   task automatic hop(input logic [31:0] sl, band, rep, typ, en);
      logic [31:0] s, g, q, nch, mp, a0, hs;
      logic [15:0] n0;
      int          k;
      rng = xs(rng);
      a0 = rng;
      wr(`USCH_ADDR_OFS, rng);
      rng = xs(rng);
      wr(`USCH_SECS_OFS, rng);
      wr(`USCH_CFG_OFS, (rep << 24) | sl);
      wr(`USCH_SLOTCFG_OFS, band);
      wr(`USCH_SLOTTIME_OFS, 32'h4);
      wr(`USCH_SLOTEN_OFS, en);
      n0 = txCount;
      wr(`USCH_CTRL_OFS, (typ << 4) | 32'h1);
      k = 0;
      do begin
         rd(`USCH_STAT_OFS, d, r);
         k++;
      end while (!d[0] && k < 300);
      chk(32'(d[0]), 32'(typ == 1));
      if (typ == 1) begin
         rd(`USCH_SEED_OFS, s, r);
         rd(`USCH_SLOT_OFS, g, r);
         nch = (band > 200) ? band / 200 : 1;
         mp = sl * nch ** (rep + 1);
         chk(s, refSeed(a0, rng, mp));
         chk(32'(s < mp || d[4:2] == 3'h4), 32'h1);
         hs = (s < mp) ? s : s >> 1;
         chk(32'(hs < mp), 32'h1);
         chk(g, hs % sl);
         chk(slotIndex, g);
         q = hs / sl;
         for (k = 0; k <= rep; k++) begin
            wr(`USCH_CTRL_OFS, (typ << 4) | (k << 8));
            rd(`USCH_CHAN_OFS, d, r);
            chk(d, q % nch);
            q = q / nch;
         end
         repeat (3 * sl * 4) @(posedge clk);
         chk(32'(txCount != n0), 32'(en != 0));
         if (en != 0) chk(lastSlot, g);
      end
      $display("test hop slots=%0d type=%0d done", sl, typ);
   endtask : hop
   task automatic reportAndStop();
      $display("checks=%0d mismatches=%0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : reportAndStop

   // Main sequence
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(`USCH_CFG_OFS, d, r);
      chk(d, `USCH_CFG_RST);
      rd(`USCH_SLOTTIME_OFS, d, r);
      chk(d, `USCH_SLOTTIME_RST);
      wr(8'h3C, 32'hFFFF);
      rd(8'h3C, d, r);
      chk({30'h0, r}, 32'h2);
      chk(d, 32'h0);
      $display("test reset and unmapped done");
      hop(2, 200, 0, 1, 32'hFFFFFFFF);
      hop(16, 1000, 3, 1, 32'hFFFFFFFF);
      hop(5, 400, 1, 1, 32'h0);
      hop(5, 400, 1, 0, 32'hFFFFFFFF);
      hop(5, 400, 1, 2, 32'hFFFFFFFF);
      for (i = 0; i < 6; i++) begin
         rng = xs(rng);
         hop(2 + rng % 15, 200 * (1 + rng[7:5] % 5), rng[9:8], 1, '1);
      end
      reportAndStop();
   end
endmodule : usch_hopper_tb_top
`default_nettype wire
